// >>> ebt_cfg.svh
`ifndef EBT_CFG_SVH
`define EBT_CFG_SVH
// ***********************
// Register addresses
// ***********************
`define EBT_A_PORT_DIR 16'hFF22
`define EBT_A_PORT_LAT 16'hFF02
`define EBT_A_CNT0 16'hFF6E
`define EBT_A_CMP0 16'hFF6F
`define EBT_A_MODE0 16'hFF70
`define EBT_A_SRC0 16'hFF71
`define EBT_A_STRIDE 16'h0004
// ***********************
// Mode control fields
// ***********************
`define EBT_B_RUN 7
`define EBT_B_PWM 6
`define EBT_B_JOIN 4
`define EBT_B_LSET 3
`define EBT_B_LRST 2
`define EBT_B_ALVL 1
`define EBT_B_OEN 0
`define EBT_MODE_RD_MASK 8'hD3
`define EBT_SRC_W 3
// ***********************
// Reset values and fixed constants
// ***********************
`define EBT_RST_DIR 8'hFF
`define EBT_RST_BYTE 8'h00
`define EBT_DIR_FIXED 8'h80
`define EBT_CNT_TOP 8'hFF
// ***********************
// Prescaler
// ***********************
`define EBT_PRE_W 11
`endif

// >>> ebt_pkg.sv
`default_nettype none
package ebt_pkg;
  typedef logic [7:0] ebt_byte_t;
  typedef logic [3:0] ebt_exp_t;
  typedef enum logic [2:0] {
    EBT_SRC_FALL = 3'h0,
    EBT_SRC_RISE = 3'h1
  } ebt_src_t;
endpackage : ebt_pkg
`default_nettype wire

// >>> ebt_timer_block.sv
`include "ebt_cfg.svh"
`default_nettype none
// Notes on behaviour
// - Interval mode: count equal to compare clears counter and pulses interrupt.
// - Count clock comes from low three bits of tick source select.
// - Match interval is compare value plus one count clocks.
// - Counter runs only while count enable bit seven is one; a joined upper half uses the lower half's bit seven.
// - Event mode counts selected input edges; match clears and interrupts.
// - Input valid edge is rising or falling, chosen by source select.
// - Output enable set: output flip-flop toggles on every match.
// - Level set alone forces output high; level reset alone forces low.
// - Mode bit six selects PWM; compare value sets active width.
// - Bit one picks PWM active level; bit zero gates the output.
// - PWM inactive until first overflow, active until match, repeat.
// - Stopping PWM count drives the output inactive.
// - Join bit of timer 1 makes timers 0 and 1 one 16-bit timer.
// - Joined 0/1 full match interrupts timers 0 and 1 and clears both.
// - Join bit of timer 2 pairs timers 1 and 2 likewise.
// - Upper half of a joined pair ignores its own source select.
// - Direction bit zero drives pin, one releases it.
// - Compare below count: counter runs to overflow before matching.
// - Source codes 000/001 are falling/rising input edge; others divide.
module ebt_timer_block (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic [15:0] cpu_addr, // Register address
  input wire ebt_pkg::ebt_byte_t cpu_wdata, // Write data
  input wire logic cpu_wr, // Write strobe
  input wire logic cpu_rd, // Read strobe
  output ebt_pkg::ebt_byte_t cpu_rdata, // Read data
  input wire logic [6:0] port2_in, // Pin levels
  output logic [6:0] port2_out, // Pin drive values
  output logic [6:0] port2_oe_n, // Pin drive enable, low
  output logic [2:0] match_irq // Match interrupt pulses
);
  import ebt_pkg::*;

  // ***********************
  // Helpers
  // ***********************
  function automatic logic div_tick(
    input logic [`EBT_PRE_W-1:0] pre,
    input ebt_exp_t k
  );
    logic [`EBT_PRE_W-1:0] mask;
    mask = `EBT_PRE_W'((`EBT_PRE_W+1)'(1) << k) - `EBT_PRE_W'(1);
    div_tick = ((pre & mask) == mask);
  endfunction : div_tick

  // Divider exponent per timer and code
  function automatic ebt_exp_t tick_exp(
    input int unsigned idx,
    input logic [2:0] code
  );
    logic [4:0] c;
    c = {2'h0, code};
    case (idx)
      0: tick_exp = 4'(c + c - 5'h3);
      1: tick_exp = 4'(c - 5'h2);
      default: tick_exp = 4'(c + 5'h2);
    endcase
  endfunction : tick_exp

  function automatic logic hit(
    input logic [15:0] a,
    input logic [15:0] base,
    input int unsigned idx
  );
    hit = (a == 16'(base + 16'(idx) * `EBT_A_STRIDE));
  endfunction : hit

  // ***********************
  // State
  // ***********************
  ebt_byte_t cnt_ff [3];
  ebt_byte_t nxt_cnt [3];
  ebt_byte_t cmp_ff [3];
  ebt_byte_t mode_ff [3];
  logic [2:0] src_ff [3];
  ebt_byte_t dir_ff;
  ebt_byte_t lat_ff;
  ebt_byte_t rdata_ff;
  logic [`EBT_PRE_W-1:0] pre_ff;
  logic [2:0] ev_s1_ff;
  logic [2:0] ev_s2_ff;
  logic [2:0] ev_d_ff;
  logic [2:0] tof_ff;
  logic [2:0] nxt_tof;
  logic [2:0] pwm_act_ff;
  logic [2:0] nxt_pwm_act;
  logic [2:0] irq_ff;
  logic [2:0] nxt_irq;
  logic [6:0] pin_ff;
  logic [6:0] nxt_pin;

  // ***********************
  // Decode
  // ***********************
  wire join_lo = mode_ff[1][`EBT_B_JOIN];
  wire join_hi = mode_ff[2][`EBT_B_JOIN];
  wire [2:0] is_up = {join_hi, join_lo, 1'b0};
  wire [2:0] is_lo = {1'b0, join_hi & ~join_lo, join_lo};
  wire wr_dir = ce & cpu_wr & (cpu_addr == `EBT_A_PORT_DIR);
  wire wr_lat = ce & cpu_wr & (cpu_addr == `EBT_A_PORT_LAT);
  logic [2:0] wr_cnt_n;
  logic [2:0] wr_cmp;
  logic [2:0] wr_mode;
  logic [2:0] wr_src;
  logic [2:0] own_eq;
  logic [2:0] src_tick;
  logic [2:0] tick;
  logic [2:0] run;
  logic [2:0] match;
  logic [2:0] t_out;
  logic [2:0] rise;
  logic [2:0] fall;
  ebt_byte_t rd_mux;

  assign rise = ev_s2_ff & ~ev_d_ff;
  assign fall = ~ev_s2_ff & ev_d_ff;

  always_comb begin
    wr_cnt_n = 3'h0;
    wr_cmp = 3'h0;
    wr_mode = 3'h0;
    wr_src = 3'h0;
    rd_mux = `EBT_RST_BYTE;
    if (cpu_addr == `EBT_A_PORT_DIR) begin
      rd_mux = dir_ff | `EBT_DIR_FIXED;
    end
    if (cpu_addr == `EBT_A_PORT_LAT) begin
      rd_mux = lat_ff;
    end
    for (int i = 0; i < 3; i++) begin
      wr_cnt_n[i] = hit(cpu_addr, `EBT_A_CNT0, i);
      wr_cmp[i] = ce & cpu_wr & hit(cpu_addr, `EBT_A_CMP0, i);
      wr_mode[i] = ce & cpu_wr & hit(cpu_addr, `EBT_A_MODE0, i);
      wr_src[i] = ce & cpu_wr & hit(cpu_addr, `EBT_A_SRC0, i);
      if (wr_cnt_n[i]) begin
        rd_mux = cnt_ff[i];
      end
      if (hit(cpu_addr, `EBT_A_CMP0, i)) begin
        rd_mux = cmp_ff[i];
      end
      if (hit(cpu_addr, `EBT_A_MODE0, i)) begin
        rd_mux = mode_ff[i] & `EBT_MODE_RD_MASK;
      end
      if (hit(cpu_addr, `EBT_A_SRC0, i)) begin
        rd_mux = {5'h00, src_ff[i]};
      end
    end
  end

  // ***********************
  // Count sources
  // ***********************
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      own_eq[i] = (cnt_ff[i] == cmp_ff[i]);
      case (src_ff[i])
        EBT_SRC_FALL: src_tick[i] = fall[i];
        EBT_SRC_RISE: src_tick[i] = rise[i];
        default: src_tick[i] = div_tick(pre_ff, tick_exp(i, src_ff[i]));
      endcase
    end
  end

  // Upper halves follow the lower half, so evaluation runs upward
  always_comb begin
    tick = 3'h0;
    run = 3'h0;
    match = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (is_up[i] && i > 0) begin
        run[i] = run[i-1];
        tick[i] = tick[i-1] & (cnt_ff[i-1] == `EBT_CNT_TOP) & ~match[i-1];
      end else begin
        run[i] = mode_ff[i][`EBT_B_RUN];
        tick[i] = src_tick[i] & run[i];
        if (is_lo[i] && i < 2) begin
          match[i] = tick[i] & own_eq[i] & own_eq[i+1];
        end else begin
          match[i] = tick[i] & own_eq[i] & ~mode_ff[i][`EBT_B_PWM];
        end
      end
    end
  end

  // ***********************
  // Next state
  // ***********************
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      nxt_cnt[i] = cnt_ff[i];
      nxt_irq[i] = match[i];
      nxt_tof[i] = tof_ff[i];
      nxt_pwm_act[i] = pwm_act_ff[i];
      if (!run[i]) begin
        nxt_cnt[i] = `EBT_RST_BYTE;
      end else if (is_up[i] && i > 0) begin
        if (match[i-1]) begin
          nxt_cnt[i] = `EBT_RST_BYTE;
          nxt_irq[i] = own_eq[i];
        end else if (tick[i]) begin
          nxt_cnt[i] = cnt_ff[i] + 8'h01;
        end
      end else if (match[i]) begin
        nxt_cnt[i] = `EBT_RST_BYTE;
      end else if (tick[i]) begin
        nxt_cnt[i] = cnt_ff[i] + 8'h01;
      end
      // PWM phase: overflow starts active, match ends it
      if (!run[i] || !mode_ff[i][`EBT_B_PWM]) begin
        nxt_pwm_act[i] = 1'b0;
      end else if (tick[i] && cnt_ff[i] == `EBT_CNT_TOP) begin
        nxt_pwm_act[i] = 1'b1;
      end else if (tick[i] && own_eq[i]) begin
        nxt_pwm_act[i] = 1'b0;
      end
      if (wr_mode[i] && cpu_wdata[`EBT_B_LSET] && !cpu_wdata[`EBT_B_LRST]) begin
        nxt_tof[i] = 1'b1;
      end else if (wr_mode[i] && !cpu_wdata[`EBT_B_LSET] && cpu_wdata[`EBT_B_LRST]) begin
        nxt_tof[i] = 1'b0;
      end else if (mode_ff[i][`EBT_B_OEN] && (match[i] || (i > 0 && is_up[i] && match[i-1]))) begin
        nxt_tof[i] = ~tof_ff[i];
      end
    end
  end

  // Inactive level of an active-low PWM is high
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!mode_ff[i][`EBT_B_OEN]) begin
        t_out[i] = 1'b0;
      end else if (mode_ff[i][`EBT_B_PWM]) begin
        t_out[i] = pwm_act_ff[i] ^ mode_ff[i][`EBT_B_ALVL];
      end else begin
        t_out[i] = tof_ff[i];
      end
    end
  end

  // Timer output reaches pin only with latch zero
  assign nxt_pin = lat_ff[6:0] | {t_out, 4'h0};

  // ***********************
  // Registers
  // ***********************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ev_s1_ff <= 3'h0;
      ev_s2_ff <= 3'h0;
      ev_d_ff <= 3'h0;
    end else if (ce) begin
      ev_s1_ff <= port2_in[6:4];
      ev_s2_ff <= ev_s1_ff;
      ev_d_ff <= ev_s2_ff;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_ff <= '0;
      tof_ff <= 3'h0;
      pwm_act_ff <= 3'h0;
      irq_ff <= 3'h0;
      pin_ff <= 7'h00;
    end else if (ce) begin
      pre_ff <= pre_ff + `EBT_PRE_W'(1);
      tof_ff <= nxt_tof;
      pwm_act_ff <= nxt_pwm_act;
      irq_ff <= nxt_irq;
      pin_ff <= nxt_pin;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        cnt_ff[i] <= `EBT_RST_BYTE;
      end
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        cmp_ff[i] <= `EBT_RST_BYTE;
        mode_ff[i] <= `EBT_RST_BYTE;
        src_ff[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_cmp[i]) begin
          cmp_ff[i] <= cpu_wdata;
        end
        if (wr_mode[i]) begin
          mode_ff[i] <= cpu_wdata & `EBT_MODE_RD_MASK;
        end
        if (wr_src[i]) begin
          src_ff[i] <= cpu_wdata[`EBT_SRC_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dir_ff <= `EBT_RST_DIR;
      lat_ff <= `EBT_RST_BYTE;
      rdata_ff <= `EBT_RST_BYTE;
    end else if (ce) begin
      if (wr_dir) begin
        dir_ff <= cpu_wdata | `EBT_DIR_FIXED;
      end
      if (wr_lat) begin
        lat_ff <= cpu_wdata;
      end
      if (cpu_rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // ***********************
  // Outputs
  // ***********************
  assign cpu_rdata = rdata_ff;
  assign match_irq = irq_ff;
  assign port2_out = pin_ff;
  assign port2_oe_n = dir_ff[6:0];

endmodule : ebt_timer_block
`default_nettype wire

// >>> ebt_timer_block_sva.sv
`default_nettype none
module ebt_timer_block_sva (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic ce, // Clock enable
  input wire logic [15:0] cpu_addr, // Address
  input wire ebt_pkg::ebt_byte_t cpu_wdata, // Write data
  input wire logic cpu_wr, // Write strobe
  input wire logic cpu_rd, // Read strobe
  input wire ebt_pkg::ebt_byte_t cpu_rdata, // Read data
  input wire logic [6:0] port2_out, // Pin values
  input wire logic [6:0] port2_oe_n, // Pin enables
  input wire logic [2:0] match_irq // Interrupts
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire rd_ok = ce && cpu_rd;
  property p_dir_wr;
    ce && cpu_wr && cpu_addr == 16'hFF22 |=> {1'b0, port2_oe_n} == ($past(cpu_wdata) & 8'h7F);
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction write not applied");
  property p_ce_hold;
    !ce && cpu_wr && cpu_addr == 16'hFF22 |=> $stable(port2_oe_n);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("write taken while frozen");
  property p_rst_out;
    $fell(rst) |-> match_irq == 3'h0 && port2_out == 7'h00 && port2_oe_n == 7'h7F;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  property p_unmap;
    rd_ok && cpu_addr == 16'hFF00 |=> cpu_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_dir_b7;
    rd_ok && cpu_addr == 16'hFF22 |=> cpu_rdata[7];
  endproperty
  a_dir_b7: assert property (p_dir_b7) else $error("direction bit 7 reads zero");
  property p_rd_hold;
    !rd_ok |=> $stable(cpu_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_mode_rd;
    rd_ok && cpu_addr inside {16'hFF70, 16'hFF74, 16'hFF78} |=> (cpu_rdata & 8'h2C) == 8'h00;
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode action bits read back");
  property p_lvl_set;
    ce && cpu_wr && cpu_addr == 16'hFF70 && cpu_wdata[7:6] == 2'b00 && cpu_wdata[3:0] == 4'h9
      |-> ##2 port2_out[4];
  endproperty
  a_lvl_set: assert property (p_lvl_set) else $error("level set did not drive high");
endmodule : ebt_timer_block_sva
bind ebt_timer_block ebt_timer_block_sva i_ebt_timer_block_sva (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
  .port2_out(port2_out), .port2_oe_n(port2_oe_n), .match_irq(match_irq));
`default_nettype wire

// >>> ebt_event_src.sv
`default_nettype none
module ebt_event_src (
  input wire logic clk_sys, // Clock
  output logic [6:0] pins // Event pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = 7'h00;
  // Three cycles each way so the input synchroniser never misses a level
  task pulse(input int b);
    @(posedge clk_sys);
    pins[b] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pins[b] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : pulse
endmodule : ebt_event_src
`default_nettype wire

// >>> ebt_timer_block_tb_top.sv
`default_nettype none
module ebt_timer_block_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ebt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  ebt_byte_t cpu_wdata = 8'h00;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  ebt_byte_t cpu_rdata, rv;
  logic [6:0] port2_out, port2_oe_n, ev_pins, pin_lvl;
  logic [2:0] match_irq;
  logic o1;
  int nw;
  int n_errors = 0;
  int num_checks = 0;
  ebt_byte_t cv [3] = '{8'h00, 8'h02, 8'hFF};
  always #20 clk_sys = ~clk_sys;
  // Wire level: design where it drives, event source elsewhere
  assign pin_lvl = (port2_oe_n & ev_pins) | (~port2_oe_n & port2_out);
  ebt_timer_block i_ebt_timer_block (.clk_sys(clk_sys), .rst(rst), .ce(ce), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .port2_in(pin_lvl),
    .port2_out(port2_out), .port2_oe_n(port2_oe_n), .match_irq(match_irq));
  ebt_event_src i_ebt_event_src (.clk_sys(clk_sys), .pins(ev_pins));
  // ***************
  // Access, wait and check tasks
  // ***************
  task automatic final_report;
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input ebt_byte_t d);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    @(negedge clk_sys);
    rv = cpu_rdata;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // Bounded wait for the next interrupt pulse; a lost pulse ends the run
  task automatic till(input int b, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (match_irq[b] !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      n_errors++;
      final_report();
    end
  endtask : till
  // Cycles from one interrupt pulse to the next
  task automatic gap(input int b, input int exp);
    int n;
    till(b, n);
    till(b, n);
    chk("gap", n, exp);
  endtask : gap
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(16'hFF22); chk("dir", rv, 8'hFF);
    rd(16'hFF00); chk("unmap", rv, 8'h00);
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(16'hFF22, 8'h00);
    ce <= 1'b1;
    rd(16'hFF22); chk("frozen", rv, 8'hFF);
    wr(16'hFF71, 8'h01); wr(16'hFF6F, 8'h03); wr(16'hFF70, 8'h80);
    i_ebt_event_src.pulse(4); i_ebt_event_src.pulse(4); cyc(6);
    rd(16'hFF6E); chk("rise", rv, 8'h02);
    wr(16'hFF70, 8'h00); wr(16'hFF71, 8'h00); wr(16'hFF70, 8'h80);
    i_ebt_event_src.pulse(4); cyc(6);
    rd(16'hFF6E); chk("fall", rv, 8'h01);
    wr(16'hFF70, 8'h00); wr(16'hFF22, 8'h00); wr(16'hFF02, 8'h00);
    chk("oe", port2_oe_n, 7'h00);
    wr(16'hFF74, 8'h09); cyc(2); chk("lvs", port2_out[5], 1'b1);
    rd(16'hFF74); chk("mrd", rv, 8'h01);
    wr(16'hFF74, 8'h05); cyc(2); chk("lvr", port2_out[5], 1'b0);
    wr(16'hFF70, 8'h09);
    cyc(2);
    chk("lvs0", port2_out[4], 1'b1);
    wr(16'hFF75, 8'h02);
    foreach (cv[i]) begin
      wr(16'hFF74, 8'h00); wr(16'hFF73, cv[i]); wr(16'hFF74, 8'h80);
      gap(1, cv[i] + 1);
    end
    // Count is 22 when compare drops to 4, so the counter must wrap first
    cyc(20);
    wr(16'hFF73, 8'h04);
    till(1, nw);
    chk("wrap", nw, 240);
    wr(16'hFF74, 8'h00); wr(16'hFF73, 8'h02); wr(16'hFF74, 8'h81); cyc(8);
    o1 = port2_out[5]; cyc(3); chk("sq", port2_out[5], !o1);
    wr(16'hFF74, 8'h00); wr(16'hFF73, 8'h80); wr(16'hFF74, 8'hC1);
    cyc(10); chk("pwm0", port2_out[5], 1'b0);
    cyc(250); chk("pwm1", port2_out[5], 1'b1);
    wr(16'hFF74, 8'h41); cyc(3); chk("pstop", port2_out[5], 1'b0);
    wr(16'hFF74, 8'hC3); cyc(10); chk("plow", port2_out[5], 1'b1);
    wr(16'hFF74, 8'h00);
    wr(16'hFF73, 8'h01); wr(16'hFF6F, 8'h01);
    wr(16'hFF71, 8'h02); wr(16'hFF75, 8'h07);
    wr(16'hFF74, 8'h90); wr(16'hFF70, 8'h80);
    gap(0, 516);
    chk("upirq", match_irq[1], 1'b1);
    wr(16'hFF70, 8'h00);
    wr(16'hFF74, 8'h00);
    wr(16'hFF73, 8'h02);
    wr(16'hFF77, 8'h00);
    wr(16'hFF75, 8'h02);
    wr(16'hFF78, 8'h90);
    wr(16'hFF74, 8'h80);
    gap(1, 3);
    chk("upirq2", match_irq[2], 1'b1);
    final_report();
  end
endmodule : ebt_timer_block_tb_top
`default_nettype wire
